// file: logic/fipc_if.sv
// Interface carrying the timed PHY reset request and its completion
`timescale 1ns/1ps
interface fipc_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport timer (input start, output busy);
endinterface

// file: logic/fipc_pkg.sv
// Shared constants for the FIFO information and power control register bank
package fipc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_RX_DATAPATH_CONTROL = 8'h78;
  localparam logic [7:0] OFF_RX_FIFO_OCC = 8'h7C;
  localparam logic [7:0] OFF_TX_FIFO_OCC = 8'h80;
  localparam logic [7:0] OFF_PWR_CTRL = 8'h84;
  localparam logic [7:0] OFF_BYTE_TEST = 8'h64;
  // Field positions
  localparam int RX_SKIP_BIT = 31;
  localparam int USED_WORDS_LSB = 16;
  localparam int PSEL_LSB = 12;
  localparam int PHY_RESET_REQUEST_BIT = 10;
  localparam int READY_BIT = 0;
  // Reset values
  localparam logic [15:0] TX_FREE_RESET = 16'h1200;
  localparam logic [7:0] WORDS_RESET = 8'h00;
  localparam logic [15:0] BYTES_RESET = 16'h0000;
  // Power states
  typedef enum logic [1:0] {
    FIPC_PS_D0 = 2'b00,
    FIPC_PS_D1 = 2'b01,
    FIPC_PS_D2 = 2'b10
  } fipc_pstate_t;
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int PHY_RESET_REQUEST_US = 100;
  localparam int PHY_RESET_REQUEST_CYCLES = PHY_RESET_REQUEST_US * CLK_MHZ;
  localparam int READY_CYCLES = 16;
endpackage

// file: logic/fipc_regs.sv
// Receive/transmit FIFO information and power control register bank
`timescale 1ns/1ps
module fipc_regs #(
  parameter int PHY_RESET_REQUEST_CYCLES = fipc_pkg::PHY_RESET_REQUEST_CYCLES,
  parameter int READY_CYCLES = fipc_pkg::READY_CYCLES
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Host register port, same clock domain
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Receive datapath
  output logic rx_frame_skip_go,
  input wire logic rx_frame_skip_done,
  input wire logic rx_frame_pushed,
  input wire logic [15:0] rx_frame_len,
  input wire logic rx_data_popped,
  input wire logic [7:0] rx_status_used_words,
  // Transmit datapath
  input wire logic [7:0] tx_status_used_words,
  input wire logic [15:0] tx_data_free_bytes,
  // Power and PHY
  output logic [1:0] power_state_select,
  output logic phy_reset_out,
  output logic device_ready
);
  fipc_if tmr ();

  logic rx_frame_skip_reg;            // Skip in progress
  logic [15:0] rx_data_used_bytes_reg; // RX data occupancy
  logic [1:0] pstate_reg;             // Current power state
  logic phy_reset_request_reg;        // PHY reset bit
  logic phy_busy_seen_reg;            // Timer has started for this request
  logic read_seen_reg;                // A read occurred since reset or wake
  logic ready_reg;                    // Device stable
  logic [$clog2(READY_CYCLES+1)-1:0] ready_cnt_reg;
  logic wr_ok;                        // Write allowed to act
  logic [15:0] rx_len_rounded;

  //////////////////////////////////////////////////////////////////////////
  // Writes act only after a read, and only to byte test while not ready
  assign wr_ok = reg_wr && read_seen_reg && ready_reg;
  // Frame length rounded up to whole words
  assign rx_len_rounded = (rx_frame_len + 16'h0003) & 16'hFFFC;

  //////////////////////////////////////////////////////////////////////////
  // Read-before-write tracking; a wake re-arms it
  always_ff @(posedge clk) begin
    if (reset) begin
      read_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == fipc_pkg::OFF_BYTE_TEST &&
          pstate_reg != fipc_pkg::FIPC_PS_D0) begin
        read_seen_reg <= 1'b0;
      end else if (reg_rd) begin
        read_seen_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Power state select; byte test write wakes to normal operation
  always_ff @(posedge clk) begin
    if (reset) begin
      pstate_reg <= fipc_pkg::FIPC_PS_D0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == fipc_pkg::OFF_BYTE_TEST &&
          pstate_reg != fipc_pkg::FIPC_PS_D0) begin
        pstate_reg <= fipc_pkg::FIPC_PS_D0;
      end else if (wr_ok && reg_addr == fipc_pkg::OFF_PWR_CTRL &&
                   reg_wdata[fipc_pkg::PSEL_LSB+:2] != 2'b11) begin
        // Code 11 is refused rather than trusted to the host
        pstate_reg <= reg_wdata[fipc_pkg::PSEL_LSB+:2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Ready drops on any state change and rises after a settle count
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_reg <= 1'b0;
      ready_cnt_reg <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == fipc_pkg::OFF_BYTE_TEST &&
          pstate_reg != fipc_pkg::FIPC_PS_D0) begin
        ready_reg <= 1'b0;
        ready_cnt_reg <= '0;
      end else if (pstate_reg != fipc_pkg::FIPC_PS_D0) begin
        // Reduced power: not ready until woken
        ready_reg <= 1'b0;
        ready_cnt_reg <= '0;
      end else if (!ready_reg) begin
        if (ready_cnt_reg == ($bits(ready_cnt_reg))'(READY_CYCLES)) begin
          ready_reg <= 1'b1;
        end else begin
          ready_cnt_reg <= ready_cnt_reg + 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive skip bit: set by host, cleared when datapath reports done
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_frame_skip_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_ok && reg_addr == fipc_pkg::OFF_RX_DATAPATH_CONTROL &&
          reg_wdata[fipc_pkg::RX_SKIP_BIT]) begin
        rx_frame_skip_reg <= 1'b1;
      end else if (rx_frame_skip_done) begin
        rx_frame_skip_reg <= 1'b0;
      end
    end
  end

  // One-cycle skip launch toward the datapath
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_frame_skip_go <= 1'b0;
    end else if (clk_en) begin
      rx_frame_skip_go <= wr_ok && !rx_frame_skip_reg &&
        reg_addr == fipc_pkg::OFF_RX_DATAPATH_CONTROL &&
        reg_wdata[fipc_pkg::RX_SKIP_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // RX data used-byte counter; a frame add and a word pop may coincide
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_data_used_bytes_reg <= fipc_pkg::BYTES_RESET;
    end else if (clk_en) begin
      rx_data_used_bytes_reg <= rx_data_used_bytes_reg
        + (rx_frame_pushed ? rx_len_rounded : 16'h0000)
        - (rx_data_popped ? 16'h0004 : 16'h0000);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // PHY reset request; writes ignored while it is set
  assign tmr.start = phy_reset_request_reg && !phy_busy_seen_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      phy_reset_request_reg <= 1'b0;
      phy_busy_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (!phy_reset_request_reg) begin
        phy_busy_seen_reg <= 1'b0;
        if (wr_ok && reg_addr == fipc_pkg::OFF_PWR_CTRL &&
            reg_wdata[fipc_pkg::PHY_RESET_REQUEST_BIT]) begin
          phy_reset_request_reg <= 1'b1;
        end
      end else if (tmr.busy) begin
        phy_busy_seen_reg <= 1'b1;
      end else if (phy_busy_seen_reg) begin
        phy_reset_request_reg <= 1'b0;
      end
    end
  end

  fipc_timer #(
    .CYCLES(PHY_RESET_REQUEST_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .port(tmr.timer)
  );

  // PHY reset pin follows the request from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      phy_reset_out <= 1'b0;
    end else if (clk_en) begin
      phy_reset_out <= phy_reset_request_reg || tmr.busy;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered read data; reserved bits and unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        fipc_pkg::OFF_RX_DATAPATH_CONTROL: begin
          reg_rdata[fipc_pkg::RX_SKIP_BIT] <= rx_frame_skip_reg;
        end
        fipc_pkg::OFF_RX_FIFO_OCC: begin
          reg_rdata <= {8'h00, rx_status_used_words,
                        rx_data_used_bytes_reg};
        end
        fipc_pkg::OFF_TX_FIFO_OCC: begin
          reg_rdata <= {8'h00, tx_status_used_words,
                        tx_data_free_bytes};
        end
        fipc_pkg::OFF_PWR_CTRL: begin
          // Always served, even in reduced power
          reg_rdata <= {18'h00000, pstate_reg, 1'b0,
                        phy_reset_request_reg, 9'h000,
                        ready_reg};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status outputs from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      power_state_select <= fipc_pkg::FIPC_PS_D0;
      device_ready <= 1'b0;
    end else if (clk_en) begin
      power_state_select <= pstate_reg;
      device_ready <= ready_reg;
    end
  end
endmodule // fipc_regs

// file: logic/fipc_timer.sv
// Down-counter that holds the PHY reset for a minimum duration
`timescale 1ns/1ps
module fipc_timer #(
  parameter int CYCLES = fipc_pkg::PHY_RESET_REQUEST_CYCLES
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Request and busy
  fipc_if.timer port
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  //////////////////////////////////////////////////////////////////////////
  // Load on start, count down to zero; busy while nonzero
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (port.start && cnt_reg == '0) begin
        cnt_reg <= CW'(CYCLES);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign port.busy = (cnt_reg != '0);
endmodule // fipc_timer

// file: sim/fipc_dp_model.sv
// Behavioural model of the FIFO datapath behind the register bank
`timescale 1ns/1ps
module fipc_dp_model #(
  parameter int SKIP_LAT = 6
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  // Requests from the registers and the bench
  input wire logic skip_go,
  input wire logic pushed,
  // Answers and levels
  output logic skip_done,
  output logic [7:0] rx_sw,
  output logic [7:0] tx_sw,
  output logic [15:0] tx_free
);
  int cnt;
  // Skip takes several cycles, so the busy bit is really seen
  always_ff @(posedge clk) begin
    skip_done <= 1'b0;
    if (reset) begin
      cnt <= 0;
      rx_sw <= 8'h00;
      tx_sw <= 8'h00;
      tx_free <= 16'h1200;
    end else begin
      if (skip_go) cnt <= SKIP_LAT;
      else if (cnt == 1) begin
        cnt <= 0;
        skip_done <= 1'b1;
      end else if (cnt > 1) cnt <= cnt - 1;
      // Each frame also queues a 256 byte echo, taken from free space with no floor check
      if (pushed) begin
        rx_sw <= rx_sw + 8'h01;
        tx_sw <= tx_sw + 8'h01;
        tx_free <= tx_free - 16'h0100;
      end
    end
  end
endmodule // fipc_dp_model

// file: sim/fipc_regs_asserts.sv
// Concurrent checks on the FIFO info and power control register ports
`timescale 1ns/1ps
module fipc_regs_asserts #(
  parameter int PHY_RESET_REQUEST_CYCLES = 2500
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Host port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Datapath levels
  input wire logic rx_frame_skip_go,
  input wire logic [7:0] rx_status_used_words,
  input wire logic [7:0] tx_status_used_words,
  input wire logic [15:0] tx_data_free_bytes,
  // Power and PHY
  input wire logic [1:0] power_state_select,
  input wire logic phy_reset_out,
  input wire logic device_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  //////////////////////////////
  // Accepted reads and skip requests
  wire logic rd_go = reg_rd && clk_en;
  wire logic wr_skip = reg_wr && clk_en && reg_wdata[31]
    && reg_addr == fipc_pkg::OFF_RX_DATAPATH_CONTROL;
  // Length of the PHY reset pulse so far
  int unsigned hold_cnt;
  always_ff @(posedge clk) begin
    if (reset || !phy_reset_out) hold_cnt <= 0;
    else if (clk_en) hold_cnt <= hold_cnt + 1;
  end
  //////////////////////////////
  property p_skip_cause;
    rx_frame_skip_go |-> $past(wr_skip) || $past(wr_skip, 2);
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("stray skip");
  property p_phy_min;
    $fell(phy_reset_out) |-> hold_cnt >= PHY_RESET_REQUEST_CYCLES;
  endproperty
  a_phy_min: assert property (p_phy_min) else $error("phy reset short");
  property p_phy_max;
    phy_reset_out |-> hold_cnt < PHY_RESET_REQUEST_CYCLES + 16;
  endproperty
  a_phy_max: assert property (p_phy_max) else $error("phy reset stuck");
  property p_ps_legal;
    power_state_select != 2'b11;
  endproperty
  a_ps_legal: assert property (p_ps_legal) else $error("bad state");
  property p_ready_up;
    $fell(reset) |-> ##[1:40] device_ready;
  endproperty
  a_ready_up: assert property (p_ready_up) else $error("never ready");
  property p_rx_occ;
    rd_go && reg_addr == fipc_pkg::OFF_RX_FIFO_OCC |=>
      reg_rdata[31:16] == {8'h00, $past(rx_status_used_words)};
  endproperty
  a_rx_occ: assert property (p_rx_occ) else $error("rx occupancy");
  property p_tx_occ;
    rd_go && reg_addr == fipc_pkg::OFF_TX_FIFO_OCC |=> reg_rdata ==
      {8'h00, $past(tx_status_used_words), $past(tx_data_free_bytes)};
  endproperty
  a_tx_occ: assert property (p_tx_occ) else $error("tx occupancy");
  property p_pmt;
    rd_go && reg_addr == fipc_pkg::OFF_PWR_CTRL |=> reg_rdata[31:14] == 18'h0
      && reg_rdata[13:12] == $past(power_state_select);
  endproperty
  a_pmt: assert property (p_pmt) else $error("power read");
  // Main scenarios reached
  c_skip: cover property (rx_frame_skip_go);
  c_phy: cover property ($fell(phy_reset_out));
  c_low: cover property (power_state_select == 2'b10);
endmodule // fipc_regs_asserts
bind fipc_regs fipc_regs_asserts #(.PHY_RESET_REQUEST_CYCLES(PHY_RESET_REQUEST_CYCLES)) u_chk (
  .clk, .reset, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .rx_frame_skip_go, .rx_status_used_words,
  .tx_status_used_words, .tx_data_free_bytes, .power_state_select,
  .phy_reset_out, .device_ready);

// file: sim/tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic rx_frame_pushed = 0, rx_data_popped = 0, rx_frame_skip_done;
  logic rx_frame_skip_go, phy_reset_out, device_ready;
  logic [7:0] reg_addr = 8'h00, rx_status_used_words, tx_status_used_words;
  logic [15:0] rx_frame_len = 16'h0000, tx_data_free_bytes;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [1:0] power_state_select;
  int num_errors = 0, samples_checked = 0;
  // Rows: frame length, running rounded byte count
  logic [31:0] rows [4] = '{32'h0001_0004, 32'h0004_0008,
    32'h0005_0010, 32'h003F_0050};
  localparam logic [7:0] PWR = fipc_pkg::OFF_PWR_CTRL;
  always #20 clk = ~clk;
  fipc_regs #(.PHY_RESET_REQUEST_CYCLES(10), .READY_CYCLES(4)) uut (.clk, .reset,
    .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .rx_frame_skip_go, .rx_frame_skip_done, .rx_frame_pushed,
    .rx_frame_len, .rx_data_popped, .rx_status_used_words,
    .tx_status_used_words, .tx_data_free_bytes, .power_state_select,
    .phy_reset_out, .device_ready);
  fipc_dp_model dp (.clk, .reset, .skip_go(rx_frame_skip_go),
    .pushed(rx_frame_pushed), .skip_done(rx_frame_skip_done),
    .rx_sw(rx_status_used_words), .tx_sw(tx_status_used_words),
    .tx_free(tx_data_free_bytes));
  //////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data lands on the same edge that takes the read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Ready may lag a wake write, so let it drop first
  task automatic wait_ready;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 60 && device_ready !== 1'b1; i++) @(negedge clk);
    chk("ready", 32'h1, {31'h0, device_ready});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wait_ready();
    foreach (rows[i]) begin
      @(posedge clk);
      rx_frame_len <= rows[i][31:16];
      rx_frame_pushed <= 1'b1;
      @(posedge clk);
      rx_frame_pushed <= 1'b0;
      rd(fipc_pkg::OFF_RX_FIFO_OCC);
      chk("rx_occ", {8'h00, 8'(i + 1), rows[i][15:0]}, d);
    end
    @(posedge clk);
    rx_data_popped <= 1'b1;
    @(posedge clk);
    rx_data_popped <= 1'b0;
    rd(fipc_pkg::OFF_RX_FIFO_OCC);
    chk("rx_pop", 32'h0004_004C, d);
    $display("test table done");
    // Skip: busy until the datapath finishes, no data reads meanwhile
    wr(fipc_pkg::OFF_RX_DATAPATH_CONTROL, 32'hFFFF_FFFF);
    rd(fipc_pkg::OFF_RX_DATAPATH_CONTROL);
    chk("skip_busy", 32'h8000_0000, d);
    for (int i = 0; i < 40 && !rx_frame_skip_done; i++) @(negedge clk);
    rd(fipc_pkg::OFF_RX_DATAPATH_CONTROL);
    chk("skip_end", 32'h0, d);
    $display("test skip done");
    // Second reset in mid-run, then a write before any read
    @(posedge clk);
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wait_ready();
    wr(PWR, 32'h0000_1000);
    rd(PWR);
    chk("no_write", 32'h1, d & 32'h0000_3001);
    rd(fipc_pkg::OFF_RX_FIFO_OCC);
    chk("rx_rst", 32'h0, d);
    rd(fipc_pkg::OFF_TX_FIFO_OCC);
    chk("tx_rst", 32'h0000_1200, d);
    $display("test reset done");
    // PHY reset: a clearing write while set must not cut it short
    wr(PWR, 32'h0000_0400);
    wr(PWR, 32'h0000_0000);
    rd(PWR);
    chk("phy_set", 32'h0000_0400, d & 32'h0000_0400);
    chk("phy_pin", 32'h1, {31'h0, phy_reset_out});
    for (int i = 0; i < 100 && phy_reset_out !== 1'b0; i++) @(negedge clk);
    rd(PWR);
    chk("phy_clr", 32'h0, d & 32'h0000_0400);
    $display("test phy done");
    // Enable low: a frame seen then must leave the byte count alone
    @(posedge clk);
    clk_en <= 1'b0;
    rx_frame_len <= 16'h0008;
    rx_frame_pushed <= 1'b1;
    @(posedge clk);
    rx_frame_pushed <= 1'b0;
    clk_en <= 1'b1;
    rd(fipc_pkg::OFF_RX_FIFO_OCC);
    chk("freeze", 32'h0001_0000, d);
    $display("test freeze done");
    // State codes 1 to 3; codes 1 and 2 are woken through the byte test place, code 3 is refused
    for (int c = 1; c < 4; c++) begin
      rd(PWR);
      wr(PWR, 32'(c) << 12);
      rd(PWR);
      chk("pstate", c == 3 ? 32'h0 : 32'(c) << 12, d & 32'h3000);
      chk("ps_pin", c == 3 ? 32'h0 : 32'(c), {30'h0, power_state_select});
      wr(fipc_pkg::OFF_BYTE_TEST, 32'h0);
      wait_ready();
      rd(PWR);
      chk("woke", 32'h1, d & 32'h0000_3001);
    end
    $display("test power done");
    complete_run();
  end
  // About 150 cycles expected; ten thousand means a hang
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
endmodule // tb_top
